// file: ufwd_ctrl.sv
`timescale 1ns/10ps
`include "ufwd_regs.svh"

// Functional notes
// - drive select codes 4, 8, 10, 14 mA
// - first edge after reset loads inverted strap high, strap low
// - strap low gives 10 mA, high 8 mA
// - multicast enable applies its bitmap, resets off
// - multicast bitmap filters, forwards or broadcasts
// - unknown VLAN enable applies its bitmap
// - unknown VLAN bitmap filters, forwards or broadcasts
// - self-address filter drops own-address frames
// - egress compare against MAC registers 104-109
// - IP multicast enable applies its bitmap
// - IP multicast bitmap filters, forwards, broadcasts
module ufwd_ctrl #(
	parameter int NPORTS = 5
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// strap and pad control
	input wire logic drive_strength_strap_pin,
	output logic [1:0] drive_sel,
	// frame lookup in, decision out
	input wire ufwd_pkg::ufwd_frame_t frame_in,
	output ufwd_pkg::ufwd_dec_t dec_out
);

	// refused at elaboration: the five-bit maps cannot carry more ports
	if (NPORTS < 1 || NPORTS > `UFWD_MAP_W) begin : g_bad_nports
		$error("NPORTS must be 1 to 5");
	end

	localparam logic [4:0] PORT_MASK = 5'((1 << NPORTS) - 1);

	ufwd_pkg::ufwd_apb_st_t st_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [1:0] drv_q;
	logic strap_done_q;
	logic mc_en_q;
	logic [4:0] mc_map_q;
	logic vid_en_q;
	logic [4:0] vid_map_q;
	logic self_en_q;
	logic ipmc_en_q;
	logic [4:0] ipmc_map_q;
	logic [7:0] mac_q [`UFWD_MAC_N];
	ufwd_pkg::ufwd_dec_t dec_q;
	ufwd_pkg::ufwd_dec_t dec_d;

	logic [9:0] widx;
	logic hit_gc16;
	logic hit_gc17;
	logic hit_gc18;
	logic hit_mac;
	logic mapped;
	logic wr_en;
	logic rd_en;
	logic [2:0] mac_sel;
	logic [31:0] rdata_d;
	logic [47:0] own_mac;

	// address decode
	assign widx = paddr[11:2];
	assign hit_gc16 = widx == `UFWD_IDX_GC16;
	assign hit_gc17 = widx == `UFWD_IDX_GC17;
	assign hit_gc18 = widx == `UFWD_IDX_GC18;
	assign hit_mac = widx >= `UFWD_IDX_MAC0 && widx <= `UFWD_IDX_MAC5;
	assign mac_sel = 3'(widx - `UFWD_IDX_MAC0);
	assign mapped = hit_gc16 | hit_gc17 | hit_gc18 | hit_mac;

	// one wait state keeps pready and prdata straight from flops
	assign wr_en = psel & penable & pready_q & pwrite & mapped;
	assign rd_en = psel & penable & ~pready_q & ~pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ufwd_pkg::UFWD_IDLE;
		end else begin
			case (st_q)
				ufwd_pkg::UFWD_IDLE: begin
					if (psel && !penable) begin
						st_q <= ufwd_pkg::UFWD_ACCESS;
					end
				end
				ufwd_pkg::UFWD_ACCESS: begin
					if (psel && penable) begin
						st_q <= ufwd_pkg::UFWD_DONE;
					end
				end
				ufwd_pkg::UFWD_DONE: begin
					st_q <= ufwd_pkg::UFWD_IDLE;
				end
				default: begin
					st_q <= ufwd_pkg::UFWD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			pslverr_q <= psel & penable & ~pready_q & ~mapped;
		end
	end

	// reserved bits read as zero
	always_comb begin
		rdata_d = 32'h0;
		if (hit_gc16) begin
			rdata_d[`UFWD_DRV_HI:`UFWD_DRV_LO] = drv_q;
			rdata_d[`UFWD_EN_BIT] = mc_en_q;
			rdata_d[`UFWD_MAP_HI:`UFWD_MAP_LO] = mc_map_q;
		end else if (hit_gc17) begin
			rdata_d[`UFWD_EN_BIT] = vid_en_q;
			rdata_d[`UFWD_MAP_HI:`UFWD_MAP_LO] = vid_map_q;
		end else if (hit_gc18) begin
			rdata_d[`UFWD_SELF_BIT] = self_en_q;
			rdata_d[`UFWD_EN_BIT] = ipmc_en_q;
			rdata_d[`UFWD_MAP_HI:`UFWD_MAP_LO] = ipmc_map_q;
		end else if (hit_mac) begin
			rdata_d[7:0] = mac_q[mac_sel];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (rd_en) begin
			prdata_q <= rdata_d;
		end
	end

	// strap caught on the first edge after release, never in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_done_q <= 1'b0;
			drv_q <= `UFWD_DRV_RST;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			drv_q <= {~drive_strength_strap_pin,
				drive_strength_strap_pin};
		end else if (wr_en && hit_gc16) begin
			drv_q <= pwdata[`UFWD_DRV_HI:`UFWD_DRV_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mc_en_q <= 1'b0;
			mc_map_q <= `UFWD_MAP_RST;
		end else if (wr_en && hit_gc16) begin
			mc_en_q <= pwdata[`UFWD_EN_BIT];
			mc_map_q <= pwdata[`UFWD_MAP_HI:`UFWD_MAP_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vid_en_q <= 1'b0;
			vid_map_q <= `UFWD_MAP_RST;
		end else if (wr_en && hit_gc17) begin
			vid_en_q <= pwdata[`UFWD_EN_BIT];
			vid_map_q <= pwdata[`UFWD_MAP_HI:`UFWD_MAP_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			self_en_q <= 1'b0;
			ipmc_en_q <= 1'b0;
			ipmc_map_q <= `UFWD_MAP_RST;
		end else if (wr_en && hit_gc18) begin
			self_en_q <= pwdata[`UFWD_SELF_BIT];
			ipmc_en_q <= pwdata[`UFWD_EN_BIT];
			ipmc_map_q <= pwdata[`UFWD_MAP_HI:`UFWD_MAP_LO];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `UFWD_MAC_N; i++) begin
				mac_q[i] <= `UFWD_MAC_RST;
			end
		end else if (wr_en && hit_mac) begin
			mac_q[mac_sel] <= pwdata[7:0];
		end
	end

	// first MAC register holds the most significant byte
	assign own_mac = {mac_q[0], mac_q[1], mac_q[2],
		mac_q[3], mac_q[4], mac_q[5]};

	// an unknown VLAN outranks an unknown group; self filter beats all
	always_comb begin
		dec_d.valid = frame_in.valid;
		dec_d.drop = 1'b0;
		dec_d.port_map = frame_in.lookup_map;
		if (frame_in.miss_vid && vid_en_q) begin
			dec_d.port_map = vid_map_q;
		end else if (frame_in.miss_da && frame_in.is_ip_mcast
			&& ipmc_en_q) begin
			dec_d.port_map = ipmc_map_q;
		end else if (frame_in.miss_da && frame_in.is_mcast
			&& !frame_in.is_ip_mcast && mc_en_q) begin
			dec_d.port_map = mc_map_q;
		end
		if (self_en_q && frame_in.dst_mac == own_mac) begin
			dec_d.drop = 1'b1;
			dec_d.port_map = 5'h00;
		end
		dec_d.port_map = dec_d.port_map & PORT_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_q <= '0;
		end else begin
			dec_q <= dec_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign drive_sel = drv_q;
	assign dec_out = dec_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_access_wait;
		psel && penable && !pready;
	endsequence

	sequence s_gc16_write;
		psel && penable && pready && pwrite && hit_gc16
			&& strap_done_q;
	endsequence

	sequence s_frame(logic c);
		frame_in.valid && c;
	endsequence

	a_apb_one_wait: assert property (
		s_setup ##1 s_access_wait |=> pready)
		else $error("apb answer not after one wait state");

	a_strap_load_bits: assert property (
		$rose(strap_done_q) |->
		drv_q == {~$past(drive_strength_strap_pin),
			$past(drive_strength_strap_pin)})
		else $error("strap not loaded as inverted high bit");

	a_strap_low_10ma: assert property (
		$rose(strap_done_q) && !$past(drive_strength_strap_pin)
		|-> drive_sel == `UFWD_DRV_10MA)
		else $error("low strap did not select 10 mA");

	a_drive_sel_write: assert property (
		s_gc16_write
		|=> drive_sel == $past(pwdata[`UFWD_DRV_HI:`UFWD_DRV_LO])
		##1 drive_sel == $past(drive_sel))
		else $error("drive select write not held");

	a_mc_map_apply: assert property (
		s_frame(frame_in.miss_da && frame_in.is_mcast
			&& !frame_in.is_ip_mcast && !frame_in.miss_vid
			&& mc_en_q && !dec_d.drop)
		|=> dec_out.valid
		&& dec_out.port_map == $past(mc_map_q & PORT_MASK))
		else $error("unknown multicast bitmap not applied");

	a_vid_map_apply: assert property (
		s_frame(frame_in.miss_vid && vid_en_q && !dec_d.drop)
		|=> dec_out.port_map == $past(vid_map_q & PORT_MASK))
		else $error("unknown vlan bitmap not applied");

	a_ipmc_map_apply: assert property (
		s_frame(frame_in.miss_da && frame_in.is_ip_mcast
			&& !frame_in.miss_vid && ipmc_en_q && !dec_d.drop)
		|=> dec_out.port_map == $past(ipmc_map_q & PORT_MASK))
		else $error("unknown ip multicast bitmap not applied");

	a_self_addr_drop: assert property (
		s_frame(self_en_q && frame_in.dst_mac == own_mac)
		|=> dec_out.drop && dec_out.port_map == 5'h00)
		else $error("self addressed frame not dropped");

	a_self_filter_off: assert property (
		!self_en_q |=> !dec_out.drop)
		else $error("frame dropped with self filter off");

	a_known_passes: assert property (
		s_frame(!frame_in.miss_da && !frame_in.miss_vid
			&& !self_en_q)
		|=> dec_out.port_map == $past(frame_in.lookup_map & PORT_MASK))
		else $error("known frame map altered");

	a_reserved_zero: assert property (
		psel && penable && pready && !pwrite
		&& $past(hit_gc17) && hit_gc17 |-> prdata[7:6] == 2'h0)
		else $error("reserved bits not zero");

	a_disabled_pass: assert property (
		s_frame(!vid_en_q && !ipmc_en_q && !mc_en_q && !self_en_q)
		|=> dec_out.port_map == $past(frame_in.lookup_map & PORT_MASK))
		else $error("disabled handling altered map");

	a_ready_from_state: assert property (
		pready == (st_q == ufwd_pkg::UFWD_DONE))
		else $error("apb ready out of step with transfer state");

	a_unmapped_error: assert property (
		psel && penable && pready |-> pslverr == !mapped)
		else $error("slave error does not match address decode");

	a_rdata_upper_zero: assert property (
		pready |-> prdata[31:8] == 24'h000000)
		else $error("read data above the byte not zero");

	a_gc18_top_zero: assert property (
		psel && penable && pready && !pwrite && hit_gc18
		|-> prdata[7] == 1'h0)
		else $error("reserved top bit of self filter register set");

	a_strap_high_8ma: assert property (
		$rose(strap_done_q) && $past(drive_strength_strap_pin)
		|-> drive_sel == `UFWD_DRV_8MA)
		else $error("high strap did not select 8 mA");

endmodule // ufwd_ctrl

// file: ufwd_regs.svh
`ifndef UFWD_REGS_SVH
`define UFWD_REGS_SVH

// register indices; byte address is four times the index
`define UFWD_IDX_GC16 10'h084
`define UFWD_IDX_GC17 10'h085
`define UFWD_IDX_GC18 10'h086
`define UFWD_IDX_MAC0 10'h068
`define UFWD_IDX_MAC5 10'h06D

// field positions
`define UFWD_DRV_HI 7
`define UFWD_DRV_LO 6
`define UFWD_EN_BIT 5
`define UFWD_SELF_BIT 6
`define UFWD_MAP_HI 4
`define UFWD_MAP_LO 0

// reset values
`define UFWD_DRV_RST 2'h1
`define UFWD_MAP_RST 5'h00
`define UFWD_MAC_RST 8'h00

// drive strength codes
`define UFWD_DRV_4MA 2'h0
`define UFWD_DRV_8MA 2'h1
`define UFWD_DRV_10MA 2'h2
`define UFWD_DRV_14MA 2'h3

// misc widths
`define UFWD_MAP_W 5
`define UFWD_MAC_N 6

`endif

// file: ufwd_pkg.sv
package ufwd_pkg;

	// one frame lookup result from the switch tables
	typedef struct packed {
		logic valid;
		logic [47:0] dst_mac;
		logic miss_da;
		logic miss_vid;
		logic is_mcast;
		logic is_ip_mcast;
		logic [4:0] lookup_map;
	} ufwd_frame_t;

	// forwarding decision
	typedef struct packed {
		logic valid;
		logic drop;
		logic [4:0] port_map;
	} ufwd_dec_t;

	typedef enum logic [1:0] {
		UFWD_IDLE,
		UFWD_ACCESS,
		UFWD_DONE
	} ufwd_apb_st_t;

endpackage

// file: tb.sv
`timescale 1ns/10ps
`include "ufwd_regs.svh"

module tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic strap = 1'b0;
	logic [1:0] drive_sel;
	ufwd_pkg::ufwd_frame_t frame_in = '0;
	ufwd_pkg::ufwd_dec_t dec_out;
	int n_fail = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic er;
	localparam logic [11:0] A16 = {`UFWD_IDX_GC16, 2'b00};
	localparam logic [11:0] A17 = {`UFWD_IDX_GC17, 2'b00};
	localparam logic [11:0] A18 = {`UFWD_IDX_GC18, 2'b00};
	localparam logic [11:0] AMAC = {`UFWD_IDX_MAC0, 2'b00};
	localparam logic [47:0] MAC = 48'h112233445566;
	logic [4:0] maps [3] = '{5'h00, 5'h03, 5'h1F};

	always #12.5 pclk = ~pclk;

	ufwd_ctrl dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.drive_strength_strap_pin(strap),
		.drive_sel(drive_sel),
		.frame_in(frame_in),
		.dec_out(dec_out)
	);

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// hang guard, well above the roughly two hundred cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one transfer; request held up to the edge that samples pready
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, 32'h0);
	endtask

	function automatic ufwd_pkg::ufwd_frame_t fr(input logic da,
			input logic vid, input logic mc, input logic ip,
			input logic [4:0] lm, input logic [47:0] mac);
		ufwd_pkg::ufwd_frame_t f;
		f = '0;
		f.valid = 1'b1;
		f.miss_da = da;
		f.miss_vid = vid;
		f.is_mcast = mc;
		f.is_ip_mcast = ip;
		f.lookup_map = lm;
		f.dst_mac = mac;
		return f;
	endfunction

	// decision is judged the cycle after the frame is presented
	task automatic send(input ufwd_pkg::ufwd_frame_t f, input logic dr,
			input logic [4:0] m);
		@(posedge pclk);
		frame_in <= f;
		@(posedge pclk);
		frame_in.valid <= 1'b0;
		#1;
		chk({25'h0, dec_out.valid, dec_out.drop, dec_out.port_map},
			{25'h0, 1'b1, dr, m});
	endtask

	task automatic do_reset(input logic s);
		@(posedge pclk);
		presetn <= 1'b0;
		strap <= s;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task automatic t_strap();
		do_reset(1'b0);
		chk({30'h0, drive_sel}, 32'h2);
		rdc(A16, 32'h80);
		rdc(A17, 32'h00);
		rdc(A18, 32'h00);
		do_reset(1'b1);
		chk({30'h0, drive_sel}, 32'h1);
		rdc(A16, 32'h40);
		$display("test strap done");
	endtask

	task automatic t_drive();
		for (int i = 0; i < 4; i++) begin
			wr(A16, {24'h0, i[1:0], 6'h00});
			chk({30'h0, drive_sel}, {30'h0, i[1:0]});
			rdc(A16, {24'h0, i[1:0], 6'h00});
		end
		$display("test drive done");
	endtask

	task automatic t_mcast();
		wr(A16, 32'h40);
		send(fr(1, 0, 1, 0, 5'h04, 48'h0), 1'b0, 5'h04);
		for (int i = 0; i < 3; i++) begin
			wr(A16, {24'h0, 3'b011, maps[i]});
			send(fr(1, 0, 1, 0, 5'h04, 48'h0), 1'b0, maps[i]);
		end
		send(fr(1, 0, 1, 1, 5'h04, 48'h0), 1'b0, 5'h04);
		$display("test multicast done");
	endtask

	task automatic t_vlan();
		wr(A17, 32'hFF);
		rdc(A17, 32'h3F);
		for (int i = 0; i < 3; i++) begin
			wr(A17, {24'h0, 3'b001, maps[i]});
			send(fr(0, 1, 0, 0, 5'h04, 48'h0), 1'b0, maps[i]);
		end
		wr(A17, 32'h00);
		send(fr(0, 1, 0, 0, 5'h04, 48'h0), 1'b0, 5'h04);
		$display("test vlan done");
	endtask

	task automatic t_ipmc();
		wr(A18, 32'hFF);
		rdc(A18, 32'h7F);
		for (int i = 0; i < 3; i++) begin
			wr(A18, {24'h0, 3'b001, maps[i]});
			send(fr(1, 0, 1, 1, 5'h04, 48'h0), 1'b0, maps[i]);
		end
		wr(A18, 32'h00);
		send(fr(1, 0, 1, 1, 5'h04, 48'h0), 1'b0, 5'h04);
		$display("test ip multicast done");
	endtask

	task automatic t_self();
		for (int i = 0; i < 6; i++)
			wr(AMAC + 12'(4 * i), {24'h0, MAC[47 - 8 * i -: 8]});
		rdc(AMAC + 12'h4, 32'h22);
		wr(A18, 32'h40);
		send(fr(0, 0, 0, 0, 5'h1F, MAC), 1'b1, 5'h00);
		send(fr(0, 0, 0, 0, 5'h1F, MAC ^ 48'h1), 1'b0, 5'h1F);
		wr(A18, 32'h00);
		send(fr(0, 0, 0, 0, 5'h1F, MAC), 1'b0, 5'h1F);
		$display("test self filter done");
	endtask

	task automatic t_unmapped();
		apb(1'b1, 12'h000, 32'hFF);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test unmapped done");
	endtask

	initial begin
		t_strap();
		t_drive();
		t_mcast();
		t_vlan();
		t_ipmc();
		t_self();
		t_unmapped();
		final_report();
	end
endmodule // tb
